// ===== logic/tfp_texel_fetch_postprocess.sv
/*
 * Texel post-processing stage of a sampling engine: fetch through a texel
 * cache, palette lookup, key masking, depth compare, box filtering, gamma
 * linearisation and 4x multisample addressing.
 * Assumes requests, memory answers and flush pulses come from logic on
 * sys_clk, and that memory answers each read only after taking it.
 */
// Summary of operation
// - Key hit only when all four channels lie inside inclusive low/high bounds.
// - Each sampler has its own key enable; clear means no kill, no replace.
// - Discard action kills the pixel if any contributing texel hits the key.
// - Zero action replaces each hitting texel with all-zero channels before filtering.
// - Key test and kill happen only for the sampler a sample or gather request names.
// - Compare requests test every fetched texel against the request reference.
// - Always gives 0.0, never 1.0; relations give 0.0 when true, else 1.0.
// - The compare outcome, not the texel, feeds the filter.
// - Compare is meant for single-channel formats only; red channel is compared.
// - Filter merges texels across levels and returns one colour per sample request; gather returns four red bytes.
// - Level filter picks level count and merging; minify/magnify pick in-level filter.
// - Gamma formats linearise red, green, blue, never alpha, before filtering.
// - Palette formats resolve indices through the palette; decompression is upstream.
// - Texels come from cache or memory; flush or sync flags invalidate the cache.
// - Load requests take a sample index selecting the multisample sample.
// - Resource info reports size in pixels; sample info reports sample count.
// - Filtered and gather requests see a 4x multisampled surface doubled in size.
// - Doubled view puts samples 0,2 on top row and 1,3 below.
`timescale 1ns/1ps
`include "tfp_cfg.svh"
module tfp_texel_fetch_postprocess #(
	parameter int NUM_SAMPLERS = 4,
	parameter int CACHE_LINES = 64
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [2:0] req_kind,
	input wire logic [$clog2(NUM_SAMPLERS)-1:0] req_sampler,
	input wire logic [15:0] req_u,
	input wire logic [15:0] req_v,
	input wire logic [1:0] req_sample_idx,
	input wire logic [7:0] req_ref,
	input wire logic req_minify,
	input wire logic [31:0] req_base_a,
	input wire logic [31:0] req_base_b,
	input wire logic [11:0] req_width,
	input wire logic [11:0] req_height,
	input wire logic [3:0] req_depth,
	input wire logic [3:0] req_mips,
	input wire logic req_gamma_encoded_format,
	input wire logic req_palette,
	input wire logic req_msaa4x,
	output logic res_valid,
	input wire logic res_ready,
	output logic [31:0] res_data,
	output logic res_kill,
	output logic mem_req_valid,
	output logic [31:0] mem_req_addr,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire logic [31:0] mem_rsp_data,
	input wire logic flush_cmd_valid,
	input wire logic flush_sampler_inv,
	input wire logic sync_cmd_valid,
	input wire logic sync_read_flush
);
	localparam int SW = $clog2(NUM_SAMPLERS);

	if (NUM_SAMPLERS < 2 || NUM_SAMPLERS > 16) begin : g_bad_samplers
		$error("tfp_texel_fetch_postprocess: NUM_SAMPLERS must lie in 2..16");
	end

	// Software-visible sampler state and palette
	logic [`TFP_CFG_WIDTH-1:0] cfg_q [NUM_SAMPLERS];
	logic [31:0] key_lo_q [NUM_SAMPLERS];
	logic [31:0] key_hi_q [NUM_SAMPLERS];
	logic [31:0] pal_q [`TFP_PAL_ENTRIES];

	logic smp_sel;
	logic pal_sel;
	logic [SW-1:0] smp_idx;
	logic [1:0] smp_ofs;
	assign smp_idx = reg_addr[SW+1:2];
	assign smp_ofs = reg_addr[1:0];
	assign smp_sel = reg_addr < 8'(NUM_SAMPLERS * `TFP_SAMPLER_STRIDE);
	assign pal_sel = (reg_addr & `TFP_REG_PAL_MASK) == `TFP_REG_PAL_BASE;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int s = 0; s < NUM_SAMPLERS; s++) begin
				cfg_q[s] <= `TFP_CFG_RESET;
				key_lo_q[s] <= `TFP_KEY_RESET;
				key_hi_q[s] <= `TFP_KEY_RESET;
			end
		end else if (clk_en && reg_wr && smp_sel) begin
			case (smp_ofs)
				`TFP_OFS_CFG: cfg_q[smp_idx] <= reg_wdata[`TFP_CFG_WIDTH-1:0];
				`TFP_OFS_KEY_LO: key_lo_q[smp_idx] <= reg_wdata;
				`TFP_OFS_KEY_HI: key_hi_q[smp_idx] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Palette holds colour data only, so it needs no reset
	always_ff @(posedge sys_clk) begin
		if (clk_en && reg_wr && pal_sel) begin
			pal_q[reg_addr[3:0]] <= reg_wdata;
		end
	end

	// Controller and request state
	tfp_pkg::tfp_state_type state_q, state_d;
	tfp_pkg::tfp_kind_type kind_q, kind_d;
	logic [2:0] t_q, t_d;
	logic [SW-1:0] smp_q, smp_d;
	logic [15:0] u_q, u_d, v_q, v_d;
	logic [1:0] sidx_q, sidx_d;
	logic [7:0] ref_q, ref_d;
	logic minify_q, minify_d, gamma_q, gamma_d, palette_q, palette_d, msaa_q, msaa_d;
	logic [31:0] base_a_q, base_a_d, base_b_q, base_b_d;
	logic [11:0] width_q, width_d;
	logic [10:0] sum_q [4];
	logic [10:0] sum_d [4];
	logic [31:0] gat_q, gat_d;
	logic kill_q, kill_d;
	logic req_ready_q, req_ready_d, res_valid_q, res_valid_d, res_kill_q, res_kill_d;
	logic [31:0] res_data_q, res_data_d;
	logic mem_req_valid_q, mem_req_valid_d;
	logic [31:0] mem_req_addr_q, mem_req_addr_d;
	logic [15:0] done_cnt_q, done_cnt_d, miss_cnt_q, miss_cnt_d;
	logic [31:0] reg_rdata_q, reg_rdata_d;

	// Settings of the sampler named by the request in flight
	logic [`TFP_CFG_WIDTH-1:0] cur_cfg;
	logic sample_kind, bil, lvl_lin, last;
	logic [1:0] shift;
	tfp_pkg::tfp_cmp_type cmp_fn;
	assign cur_cfg = cfg_q[smp_q];
	assign cmp_fn = tfp_pkg::tfp_cmp_type'(cur_cfg[`TFP_CFG_CMP_MSB:`TFP_CFG_CMP_LSB]);
	assign sample_kind = kind_q == tfp_pkg::KIND_SAMPLE || kind_q == tfp_pkg::KIND_SAMPLE_C;
	assign bil = kind_q == tfp_pkg::KIND_GATHER || (sample_kind && (minify_q ?
		cur_cfg[`TFP_CFG_MIN] : cur_cfg[`TFP_CFG_MAG]));
	assign lvl_lin = sample_kind && cur_cfg[`TFP_CFG_LVL_MSB:`TFP_CFG_LVL_LSB]
		== tfp_pkg::LVL_LINEAR;
	assign shift = {bil, lvl_lin};
	assign last = t_q == {lvl_lin, bil, bil};

	// Texel address: t_q = {level B, dy, dx}
	logic [15:0] uu, vv, px, py;
	logic [11:0] width_e;
	logic [1:0] samp;
	logic dbl;
	logic [31:0] pix, texel_addr;
	assign uu = (t_q[2] ? {1'b0, u_q[15:1]} : u_q) + {15'h0, t_q[0]};
	assign vv = (t_q[2] ? {1'b0, v_q[15:1]} : v_q) + {15'h0, t_q[1]};
	assign width_e = t_q[2] ? {1'b0, width_q[11:1]} : width_q;
	assign dbl = msaa_q && kind_q != tfp_pkg::KIND_LOAD;
	assign px = dbl ? {1'b0, uu[15:1]} : uu;
	assign py = dbl ? {1'b0, vv[15:1]} : vv;
	// Doubled view: column picks sample bit 1, row picks sample bit 0
	assign samp = dbl ? {uu[0], vv[0]} : (msaa_q ? sidx_q : 2'h0);
	assign pix = {16'h0, py} * {20'h0, width_e} + {16'h0, px};
	assign texel_addr = (t_q[2] ? base_b_q : base_a_q) + (msaa_q ? {pix[29:0], samp} : pix);

	logic cache_hit, cache_inv, cache_fill;
	logic [31:0] cache_data;
	assign cache_inv = (flush_cmd_valid && flush_sampler_inv)
		|| (sync_cmd_valid && sync_read_flush);
	assign cache_fill = state_q == tfp_pkg::ST_MEM && mem_rsp_valid;

	tfp_texel_cache #(
		.LINES(CACHE_LINES)
	) u_cache (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.invalidate(cache_inv),
		.look_addr(texel_addr),
		.look_hit(cache_hit),
		.look_data(cache_data),
		.fill(cache_fill),
		.fill_addr(mem_req_addr_q),
		.fill_data(mem_rsp_data)
	);

	// Per-texel processing chain
	logic [31:0] raw, pal_val, keyed, lin, post, val;
	logic [3:0] in_range;
	logic key_hit, rel;
	logic [7:0] cmp_val;
	assign raw = state_q == tfp_pkg::ST_MEM ? mem_rsp_data : cache_data;
	assign pal_val = palette_q ? pal_q[raw[3:0]] : raw;

	for (genvar c = 0; c < 4; c++) begin : g_key
		assign in_range[c] = pal_val[c*8 +: 8] >= key_lo_q[smp_q][c*8 +: 8]
			&& pal_val[c*8 +: 8] <= key_hi_q[smp_q][c*8 +: 8];
	end

	// Only sample-type and gather requests reference a sampler's key state
	assign key_hit = &in_range && cur_cfg[`TFP_CFG_KEY_EN]
		&& (sample_kind || kind_q == tfp_pkg::KIND_GATHER);
	assign keyed = key_hit && cur_cfg[`TFP_CFG_KEY_ACT] ? 32'h0000_0000 : pal_val;

	tfp_gamma_linear u_gamma (
		.texel_in(keyed),
		.texel_out(lin)
	);
	assign post = gamma_q ? lin : keyed;

	// Single-channel texels carry their value in the red byte
	always_comb begin
		case (cmp_fn)
			tfp_pkg::CMP_ALWAYS: rel = 1'b1;
			tfp_pkg::CMP_NEVER: rel = 1'b0;
			tfp_pkg::CMP_LT: rel = post[7:0] < ref_q;
			tfp_pkg::CMP_EQ: rel = post[7:0] == ref_q;
			tfp_pkg::CMP_LE: rel = post[7:0] <= ref_q;
			tfp_pkg::CMP_GT: rel = post[7:0] > ref_q;
			tfp_pkg::CMP_NE: rel = post[7:0] != ref_q;
			tfp_pkg::CMP_GE: rel = post[7:0] >= ref_q;
			default: rel = 1'b0;
		endcase
	end
	assign cmp_val = rel ? `TFP_CMP_PASS : `TFP_CMP_FAIL;
	assign val = kind_q == tfp_pkg::KIND_SAMPLE_C ? {4{cmp_val}} : post;

	// Controller: next values
	always_comb begin
		state_d = state_q;
		kind_d = kind_q;
		t_d = t_q;
		smp_d = smp_q;
		u_d = u_q;
		v_d = v_q;
		sidx_d = sidx_q;
		ref_d = ref_q;
		minify_d = minify_q;
		gamma_d = gamma_q;
		palette_d = palette_q;
		msaa_d = msaa_q;
		base_a_d = base_a_q;
		base_b_d = base_b_q;
		width_d = width_q;
		sum_d = sum_q;
		gat_d = gat_q;
		kill_d = kill_q;
		res_valid_d = res_valid_q;
		res_kill_d = res_kill_q;
		res_data_d = res_data_q;
		mem_req_valid_d = mem_req_valid_q;
		mem_req_addr_d = mem_req_addr_q;
		done_cnt_d = done_cnt_q;
		miss_cnt_d = miss_cnt_q;
		case (state_q)
			tfp_pkg::ST_IDLE: begin
				if (req_valid && req_ready_q) begin
					kind_d = tfp_pkg::tfp_kind_type'(req_kind);
					smp_d = req_sampler;
					u_d = req_u;
					v_d = req_v;
					sidx_d = req_sample_idx;
					ref_d = req_ref;
					minify_d = req_minify;
					gamma_d = req_gamma_encoded_format;
					palette_d = req_palette;
					msaa_d = req_msaa4x;
					base_a_d = req_base_a;
					base_b_d = req_base_b;
					width_d = req_width;
					t_d = 3'h0;
					for (int c = 0; c < 4; c++) begin
						sum_d[c] = 11'h000;
					end
					gat_d = 32'h0000_0000;
					kill_d = 1'b0;
					if (req_kind == tfp_pkg::KIND_RESINFO) begin
						res_data_d = {req_mips, req_depth, req_height, req_width};
						res_kill_d = 1'b0;
						res_valid_d = 1'b1;
						state_d = tfp_pkg::ST_OUT;
					end else if (req_kind == tfp_pkg::KIND_SAMPLEINFO) begin
						res_data_d = {28'h0, req_msaa4x ? `TFP_MSAA_SAMPLES
							: `TFP_SINGLE_SAMPLE};
						res_kill_d = 1'b0;
						res_valid_d = 1'b1;
						state_d = tfp_pkg::ST_OUT;
					end else begin
						state_d = tfp_pkg::ST_LOOK;
					end
				end
			end
			tfp_pkg::ST_LOOK: begin
				if (!cache_hit) begin
					mem_req_valid_d = 1'b1;
					mem_req_addr_d = texel_addr;
					miss_cnt_d = miss_cnt_q + 16'h0001;
					state_d = tfp_pkg::ST_MEM;
				end
			end
			tfp_pkg::ST_MEM: begin
				if (mem_req_valid_q && mem_req_ready) begin
					mem_req_valid_d = 1'b0;
				end
			end
			tfp_pkg::ST_OUT: begin
				if (res_ready) begin
					res_valid_d = 1'b0;
					res_kill_d = 1'b0;
					done_cnt_d = done_cnt_q + 16'h0001;
					state_d = tfp_pkg::ST_IDLE;
				end
			end
			default: state_d = tfp_pkg::ST_IDLE;
		endcase
		// A texel arrives either from a cache hit or from memory
		if ((state_q == tfp_pkg::ST_LOOK && cache_hit) || cache_fill) begin
			for (int c = 0; c < 4; c++) begin
				sum_d[c] = sum_q[c] + {3'h0, val[c*8 +: 8]};
			end
			gat_d[{t_q[1:0], 3'h0} +: 8] = val[7:0];
			kill_d = kill_q || (key_hit && !cur_cfg[`TFP_CFG_KEY_ACT]);
			if (last) begin
				for (int c = 0; c < 4; c++) begin
					res_data_d[c*8 +: 8] = 8'(sum_d[c] >> shift);
				end
				if (kind_q == tfp_pkg::KIND_GATHER) begin
					res_data_d = gat_d;
				end
				res_kill_d = kill_d;
				res_valid_d = 1'b1;
				state_d = tfp_pkg::ST_OUT;
			end else begin
				t_d = t_q + (bil ? 3'h1 : 3'h4);
				state_d = tfp_pkg::ST_LOOK;
			end
		end
		// Requests are taken only while idle, which keeps results in order
		req_ready_d = state_d == tfp_pkg::ST_IDLE;
		if (reg_wr && reg_addr == `TFP_REG_COUNT) begin
			done_cnt_d = 16'h0000;
			miss_cnt_d = 16'h0000;
		end
	end

	// Register read data stand only in the cycle after the read strobe
	always_comb begin
		reg_rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			if (smp_sel) begin
				case (smp_ofs)
					`TFP_OFS_CFG: reg_rdata_d = {{(32-`TFP_CFG_WIDTH){1'b0}}, cfg_q[smp_idx]};
					`TFP_OFS_KEY_LO: reg_rdata_d = key_lo_q[smp_idx];
					`TFP_OFS_KEY_HI: reg_rdata_d = key_hi_q[smp_idx];
					default: reg_rdata_d = 32'h0000_0000;
				endcase
			end else if (pal_sel) begin
				reg_rdata_d = pal_q[reg_addr[3:0]];
			end else if (reg_addr == `TFP_REG_STATUS) begin
				reg_rdata_d = {27'h0, kill_q, state_q};
			end else if (reg_addr == `TFP_REG_COUNT) begin
				reg_rdata_d = {done_cnt_q, miss_cnt_q};
			end
		end
	end

	// Controller: registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= tfp_pkg::ST_IDLE;
			kind_q <= tfp_pkg::KIND_SAMPLE;
			t_q <= 3'h0;
			smp_q <= '0;
			kill_q <= 1'b0;
			req_ready_q <= 1'b0;
			res_valid_q <= 1'b0;
			res_kill_q <= 1'b0;
			res_data_q <= 32'h0000_0000;
			mem_req_valid_q <= 1'b0;
			mem_req_addr_q <= 32'h0000_0000;
			done_cnt_q <= 16'h0000;
			miss_cnt_q <= 16'h0000;
			reg_rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			state_q <= state_d;
			kind_q <= kind_d;
			t_q <= t_d;
			smp_q <= smp_d;
			kill_q <= kill_d;
			req_ready_q <= req_ready_d;
			res_valid_q <= res_valid_d;
			res_kill_q <= res_kill_d;
			res_data_q <= res_data_d;
			mem_req_valid_q <= mem_req_valid_d;
			mem_req_addr_q <= mem_req_addr_d;
			done_cnt_q <= done_cnt_d;
			miss_cnt_q <= miss_cnt_d;
			reg_rdata_q <= reg_rdata_d;
		end
	end

	// Request operands are only read while the controller is busy
	always_ff @(posedge sys_clk) begin
		if (clk_en) begin
			u_q <= u_d;
			v_q <= v_d;
			sidx_q <= sidx_d;
			ref_q <= ref_d;
			minify_q <= minify_d;
			gamma_q <= gamma_d;
			palette_q <= palette_d;
			msaa_q <= msaa_d;
			base_a_q <= base_a_d;
			base_b_q <= base_b_d;
			width_q <= width_d;
			sum_q <= sum_d;
			gat_q <= gat_d;
		end
	end

	assign req_ready = req_ready_q;
	assign res_valid = res_valid_q;
	assign res_data = res_data_q;
	assign res_kill = res_kill_q;
	assign mem_req_valid = mem_req_valid_q;
	assign mem_req_addr = mem_req_addr_q;
	assign reg_rdata = reg_rdata_q;
endmodule // tfp_texel_fetch_postprocess

// ===== logic/tfp_cfg.svh
/*
 * Register offsets, field positions, reset values and sizes of the texel
 * post-processing stage. Assumes word-indexed register addresses on an
 * 8-bit plain register port.
 */
`ifndef TFP_CFG_SVH
`define TFP_CFG_SVH

// Per-sampler block: word index = sampler * stride + offset
`define TFP_SAMPLER_STRIDE 4
`define TFP_OFS_CFG 2'h0
`define TFP_OFS_KEY_LO 2'h1
`define TFP_OFS_KEY_HI 2'h2
`define TFP_REG_PAL_BASE 8'h80
`define TFP_REG_PAL_MASK 8'hf0
`define TFP_REG_STATUS 8'hc0
`define TFP_REG_COUNT 8'hc1

// Sampler configuration word fields
`define TFP_CFG_KEY_EN 0
`define TFP_CFG_KEY_ACT 1
`define TFP_CFG_CMP_LSB 2
`define TFP_CFG_CMP_MSB 4
`define TFP_CFG_MIN 5
`define TFP_CFG_MAG 6
`define TFP_CFG_LVL_LSB 7
`define TFP_CFG_LVL_MSB 8
`define TFP_CFG_WIDTH 9
`define TFP_CFG_RESET 9'h000
`define TFP_KEY_RESET 32'h0000_0000

`define TFP_PAL_ENTRIES 16
`define TFP_MSAA_SAMPLES 4'h4
`define TFP_SINGLE_SAMPLE 4'h1
`define TFP_CMP_PASS 8'h00
`define TFP_CMP_FAIL 8'hff

`endif

// ===== logic/tfp_pkg.sv
/*
 * Types of the texel post-processing stage: controller states, request
 * kinds, compare functions and level-filter modes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tfp_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOOK = 4'b0010,
		ST_MEM = 4'b0100,
		ST_OUT = 4'b1000
	} tfp_state_type;

	typedef enum logic [2:0] {
		KIND_SAMPLE = 3'h0,
		KIND_SAMPLE_C = 3'h1,
		KIND_LOAD = 3'h2,
		KIND_GATHER = 3'h3,
		KIND_RESINFO = 3'h4,
		KIND_SAMPLEINFO = 3'h5
	} tfp_kind_type;

	typedef enum logic [2:0] {
		CMP_ALWAYS = 3'h0,
		CMP_NEVER = 3'h1,
		CMP_LT = 3'h2,
		CMP_EQ = 3'h3,
		CMP_LE = 3'h4,
		CMP_GT = 3'h5,
		CMP_NE = 3'h6,
		CMP_GE = 3'h7
	} tfp_cmp_type;

	typedef enum logic [1:0] {
		LVL_NONE = 2'h0,
		LVL_NEAREST = 2'h1,
		LVL_LINEAR = 2'h2
	} tfp_level_type;

endpackage

// ===== logic/tfp_texel_cache.sv
/*
 * Direct-mapped texel cache, one 32-bit texel per line, combinational lookup.
 * Assumes one clock, synchronous reset and a same-clock invalidate pulse.
 */
`timescale 1ns/1ps
module tfp_texel_cache #(
	parameter int LINES = 64
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic invalidate,
	input wire logic [31:0] look_addr,
	output logic look_hit,
	output logic [31:0] look_data,
	input wire logic fill,
	input wire logic [31:0] fill_addr,
	input wire logic [31:0] fill_data
);
	localparam int IW = $clog2(LINES);

	if (LINES < 2 || (1 << IW) != LINES) begin : g_bad_lines
		$error("tfp_texel_cache: LINES must be a power of two, at least 2");
	end

	logic valid_q [LINES];
	logic [31-IW:0] tag_q [LINES];
	logic [31:0] data_q [LINES];

	assign look_hit = valid_q[look_addr[IW-1:0]] && tag_q[look_addr[IW-1:0]] == look_addr[31:IW];
	assign look_data = data_q[look_addr[IW-1:0]];

	// Invalidate beats a fill in the same cycle so no stale line survives
	always_ff @(posedge sys_clk) begin
		if (sys_rst || (clk_en && invalidate)) begin
			for (int i = 0; i < LINES; i++) begin
				valid_q[i] <= 1'b0;
			end
		end else if (clk_en && fill) begin
			valid_q[fill_addr[IW-1:0]] <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (clk_en && fill) begin
			tag_q[fill_addr[IW-1:0]] <= fill_addr[31:IW];
			data_q[fill_addr[IW-1:0]] <= fill_data;
		end
	end
endmodule // tfp_texel_cache

// ===== logic/tfp_gamma_linear.sv
/*
 * Gamma-to-linear conversion of the colour channels of an RGBA8 texel.
 * Alpha in bits 31:24 passes untouched. Purely combinational.
 */
`timescale 1ns/1ps
module tfp_gamma_linear (
	input wire logic [31:0] texel_in,
	output logic [31:0] texel_out
);
	// Curve x^2.4 sampled at 17 knots, interpolated linearly between them
	function automatic logic [7:0] knot(input logic [4:0] i);
		case (i)
			5'h00: knot = 8'h00;
			5'h01: knot = 8'h00;
			5'h02: knot = 8'h02;
			5'h03: knot = 8'h05;
			5'h04: knot = 8'h09;
			5'h05: knot = 8'h10;
			5'h06: knot = 8'h18;
			5'h07: knot = 8'h23;
			5'h08: knot = 8'h30;
			5'h09: knot = 8'h40;
			5'h0a: knot = 8'h53;
			5'h0b: knot = 8'h68;
			5'h0c: knot = 8'h80;
			5'h0d: knot = 8'h9b;
			5'h0e: knot = 8'hb9;
			5'h0f: knot = 8'hda;
			default: knot = 8'hff;
		endcase
	endfunction

	for (genvar c = 0; c < 3; c++) begin : g_chan
		logic [7:0] lo;
		logic [7:0] step;
		logic [11:0] prod;
		assign lo = knot({1'b0, texel_in[c*8+4 +: 4]});
		assign step = knot({1'b0, texel_in[c*8+4 +: 4]} + 5'h01) - lo;
		assign prod = step * {4'h0, texel_in[c*8 +: 4]};
		assign texel_out[c*8 +: 8] = lo + prod[11:4];
	end
	assign texel_out[31:24] = texel_in[31:24];
endmodule // tfp_gamma_linear

// ===== tb/tfp_texel_fetch_postprocess_props.sv
/* Assertions on the ports of the texel post-processing stage.
   Assumes one clock, synchronous active-high reset, clk_en held high. */
`timescale 1ns/1ps
module tfp_texel_fetch_postprocess_props (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [2:0] req_kind,
	input wire logic [11:0] req_width,
	input wire logic [11:0] req_height,
	input wire logic [3:0] req_depth,
	input wire logic [3:0] req_mips,
	input wire logic req_msaa4x,
	input wire logic res_valid,
	input wire logic res_ready,
	input wire logic [31:0] res_data,
	input wire logic res_kill,
	input wire logic mem_req_valid,
	input wire logic mem_req_ready,
	input wire logic [31:0] mem_req_addr
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	AST_RST_IDLE: assert property (disable iff (1'b0) sys_rst |=>
		!req_ready && !res_valid && !res_kill && !mem_req_valid) else $error("busy after reset");
	AST_RDATA_ZERO: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside answer cycle");
	AST_READY_IDLE: assert property (req_ready |-> !res_valid && !mem_req_valid)
		else $error("ready while busy");
	AST_TAKE: assert property (req_valid && req_ready |=> !req_ready)
		else $error("second request taken");
	AST_HOLD: assert property (res_valid && !res_ready |=>
		res_valid && $stable(res_data) && $stable(res_kill)) else $error("result moved");
	AST_HANDOFF: assert property (res_valid && res_ready |=> !res_valid && req_ready)
		else $error("handoff wrong");
	AST_KILL: assert property (res_kill |-> res_valid)
		else $error("kill without result");
	AST_RESINFO: assert property (req_valid && req_ready && req_kind == 3'h4 |=>
		res_valid && res_data == {$past(req_mips), $past(req_depth), $past(req_height),
		$past(req_width)}) else $error("size info wrong");
	AST_SAMPINFO: assert property (req_valid && req_ready && req_kind == 3'h5 |=>
		res_valid && res_data == ($past(req_msaa4x) ? 32'h4 : 32'h1)) else $error("sample info wrong");
	AST_MEM_HOLD: assert property (mem_req_valid && !mem_req_ready |=>
		mem_req_valid && $stable(mem_req_addr)) else $error("memory request moved");
	AST_MEM_DROP: assert property (mem_req_valid && mem_req_ready |=> !mem_req_valid)
		else $error("memory request repeated");
endmodule // tfp_texel_fetch_postprocess_props

// ===== tb/tfp_mem_model.sv
/* Texture memory behind the texel fetch: answers each read one cycle after
   taking it, data = low address byte in all four channels. */
`timescale 1ns/1ps
module tfp_mem_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic mem_req_valid,
	input wire logic [31:0] mem_req_addr,
	output logic mem_req_ready,
	output logic mem_rsp_valid,
	output logic [31:0] mem_rsp_data
);
	logic [1:0] cnt_q;
	logic [7:0] adr_q;
	always_ff @(posedge sys_clk) begin
		cnt_q <= sys_rst ? 2'h0 : cnt_q + 2'h1;
		mem_rsp_valid <= !sys_rst && mem_req_valid && mem_req_ready;
		adr_q <= (mem_req_valid && mem_req_ready) ? mem_req_addr[7:0] : adr_q;
	end
	// Refuses one cycle in four so the fetch path meets a slow memory
	assign mem_req_ready = cnt_q != 2'h0;
	// Off the answer cycle the bus shows the inverse, never a stale copy
	assign mem_rsp_data = mem_rsp_valid ? {4{adr_q}} : ~{4{adr_q}};
endmodule // tfp_mem_model

// ===== tb/tfp_texel_fetch_postprocess_test.sv
/* Self-checking bench of the texel post-processing stage.
   Assumes the memory model on the far side and the default parameters. */
`timescale 1ns/1ps
module tfp_texel_fetch_postprocess_test;
	typedef struct packed {logic [3:0] k, s; logic [11:0] c; logic [7:0] u, v, rf;
		logic [3:0] fl; logic [31:0] x; logic [3:0] kl;} tfp_row_type;
	logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic req_valid = 1'b0, res_ready = 1'b0, req_minify, req_gamma_encoded_format;
	logic req_palette, req_msaa4x, mem_req_valid, req_ready, res_valid, res_kill;
	logic mem_req_ready, mem_rsp_valid, flush_cmd_valid = 1'b0, flush_sampler_inv = 1'b0;
	logic sync_cmd_valid = 1'b0, sync_read_flush = 1'b0;
	logic [1:0] req_sampler, req_sample_idx;
	logic [2:0] req_kind;
	logic [3:0] req_depth, req_mips;
	logic [7:0] reg_addr = 8'h00, req_ref;
	logic [11:0] req_width = 12'h010, req_height = 12'h008;
	logic [15:0] req_u, req_v;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, req_base_a = 32'h0, req_base_b = 32'h80;
	logic [31:0] res_data, mem_req_addr, mem_rsp_data, d;
	int err_total = 0, checks = 0, cyc = 0, mreq = 0, i;
	tfp_row_type rows [24];
	tfp_texel_fetch_postprocess dut (.*);
	tfp_mem_model far (.*);
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (mem_req_valid && mem_req_ready)
			mreq <= mreq + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
	endtask
	task automatic put(input tfp_row_type t);
		req_kind <= t.k[2:0];
		req_sampler <= t.s[1:0];
		req_u <= {8'h00, t.u};
		req_v <= {8'h00, t.v};
		req_ref <= t.rf;
		req_sample_idx <= t.rf[1:0];
		req_depth <= t.rf[3:0];
		req_mips <= t.rf[7:4];
		req_minify <= t.fl[0];
		req_gamma_encoded_format <= t.fl[1];
		req_palette <= t.fl[2];
		req_msaa4x <= t.fl[3];
	endtask
	task automatic run(input tfp_row_type t);
		int n;
		wr({4'h0, t.s[1:0], 2'h0}, {20'h0, t.c});
		do @(negedge sys_clk); while (req_ready !== 1'b1);
		@(posedge sys_clk);
		put(t);
		req_valid <= 1'b1;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		for (n = 0; n < 300 && res_valid !== 1'b1; n++) @(negedge sys_clk);
		// Stall the taker so the result has to stand
		repeat (2) @(posedge sys_clk);
		chk("res_data", res_data, t.x);
		chk("res_kill", {31'h0, res_kill}, {28'h0, t.kl});
		res_ready <= 1'b1;
		@(posedge sys_clk);
		res_ready <= 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		rows = '{84'h0_0_000_03_02_00_0_23232323_0,
			84'h1_3_000_03_02_30_0_00000000_0,
			84'h1_3_004_03_02_30_0_ffffffff_0, 84'h1_3_008_03_02_30_0_00000000_0,
			84'h1_3_00c_03_02_30_0_ffffffff_0, 84'h1_3_010_03_02_30_0_00000000_0,
			84'h1_3_014_03_02_30_0_ffffffff_0, 84'h1_3_018_03_02_30_0_00000000_0,
			84'h1_3_01c_03_02_30_0_ffffffff_0,
			84'h0_1_001_00_01_00_0_10101010_1, 84'h0_1_001_00_02_00_0_20202020_1,
			84'h0_2_003_05_01_00_0_00000000_0,
			84'h0_1_002_05_01_00_0_15151515_0,
			84'h0_1_021_00_00_00_1_08080808_1,
			84'h1_3_028_00_00_05_1_7f7f7f7f_0,
			84'h0_0_100_02_02_00_0_55555555_0,
			84'h0_0_000_00_02_00_2_20020202_0,
			84'h0_0_000_03_00_00_4_a1b2c3d4_0,
			84'h2_1_001_04_00_02_8_12121212_0,
			84'h0_0_000_03_02_00_8_46464646_0,
			84'h3_0_000_02_03_00_0_43423332_0,
			84'h4_0_000_00_00_31_0_31008010_0, 84'h5_0_000_00_00_00_8_00000004_0,
			84'h5_0_000_00_00_00_0_00000001_0};
		put('0);
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(8'h04, d);
		chk("cfg reset", d, 32'h0);
		wr(8'h00, 32'h1ff);
		rd(8'h00, d);
		chk("cfg readback", d, 32'h1ff);
		wr(8'hc0, 32'hffffffff);
		rd(8'hc0, d);
		chk("status", d, 32'h1);
		rd(8'h7f, d);
		chk("unmapped", d, 32'h0);
		$display("register test done");
		wr(8'h83, 32'ha1b2c3d4);
		wr(8'h05, 32'h10101010);
		wr(8'h06, 32'h20202020);
		wr(8'h09, 32'h10101010);
		wr(8'h0a, 32'h20202020);
		for (i = 0; i < 24; i++) begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		// Odd cases invalidate the cache, so the repeated texel must be read again
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			flush_cmd_valid <= i == 1 || i == 2;
			flush_sampler_inv <= i == 1;
			sync_cmd_valid <= i == 3;
			sync_read_flush <= i == 3;
			@(posedge sys_clk);
			flush_cmd_valid <= 1'b0;
			sync_cmd_valid <= 1'b0;
			mreq = 0;
			run(rows[0]);
			chk("mem reads", 32'(mreq), {31'h0, i[0]});
			$display("flush case %0d done", i);
		end
		rd(8'hc1, d);
		chk("counts", d, 32'h001c_0012);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(8'h04, d);
		chk("cfg after reset", d, 32'h0);
		$display("reset test done");
		stop_test();
	end
endmodule // tfp_texel_fetch_postprocess_test
bind tfp_texel_fetch_postprocess tfp_texel_fetch_postprocess_props props (.*);
